/* File: logic/status_led_defs.svh */
// Timing and code constants for the status LED flash encoder.
`ifndef STATUS_LED_DEFS_SVH
`define STATUS_LED_DEFS_SVH

`define LED_CLOCK_HZ        100000000
`define LED_LONG_ON_MS      1000
`define LED_LONG_OFF_MS     1000
`define LED_SHORT_ON_MS     200
`define LED_SHORT_OFF_MS    200
`define LED_GAP_MS          3000
`define LED_TEST_HALF_MS    250
`define LED_MS_CYCLES       (`LED_CLOCK_HZ / 1000)
`define LED_CODE_MAX        99
`define LED_DIGIT_MAX       4'h9
`define LED_CODE_W          7

`endif

/* File: logic/status_led_pkg.sv */
// Types shared by the status LED flash encoder.
package status_led_pkg;

    typedef enum logic [2:0]
    {
        ST_TEST       = 3'b000,
        ST_GAP        = 3'b001,
        ST_LONG_ON    = 3'b011,
        ST_LONG_OFF   = 3'b010,
        ST_SHORT_ON   = 3'b110,
        ST_SHORT_OFF  = 3'b111,
        ST_READY      = 3'b101
    } led_state_t;

endpackage

/* File: logic/ms_tick.sv */
// Millisecond time base derived from the system clock.
`timescale 1ns/1ps
`include "status_led_defs.svh"

module ms_tick
#(
    parameter int CYCLES_PER_MS = `LED_MS_CYCLES
)
(
    input  wire logic clock,   // System clock.
    input  wire logic rst_n,   // Synchronous reset, active low.
    output logic      tick     // One-cycle pulse each millisecond.
);

    localparam int CW = $clog2(CYCLES_PER_MS + 1);

    if (CYCLES_PER_MS < 1)
    begin : g_chk_cycles
        $error("CYCLES_PER_MS must be at least one");
    end

    logic [CW-1:0] count_reg;
    wire           wrap = (count_reg == CW'(CYCLES_PER_MS - 1));

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            count_reg <= '0;
        else if (wrap)
            count_reg <= '0;
        else
            count_reg <= count_reg + CW'(1);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            tick <= 1'b0;
        else
            tick <= wrap;
    end

endmodule

/* File: logic/status_led_flash_encoder.sv */
// Status LED driver: self-test blink, steady ready and flashed two-digit codes.
`timescale 1ns/1ps
`include "status_led_defs.svh"

// ****************************************************************
// Overview of operation
// R1 - Blink LED while self test runs.
// R2 - Steady on once tests pass and addressed.
// R3 - Accept codes zero to ninety-nine.
// R4 - Three second dark gap, repeat forever.
// R5 - Long flash: one second on, one off.
// R6 - Long flash count is tens plus one.
// R7 - Short flash on for one fifth second.
// R8 - Short flash count is ones plus one.
// R9 - After upgrade, flash the result code.
// R10 - Internal error leaves steady, flashes code.
// R11 - Short flash off one fifth second.
// ****************************************************************

module status_led_flash_encoder
#(
    parameter int CYCLES_PER_MS = `LED_MS_CYCLES,
    parameter int LONG_ON_MS    = `LED_LONG_ON_MS,
    parameter int LONG_OFF_MS   = `LED_LONG_OFF_MS,
    parameter int SHORT_ON_MS   = `LED_SHORT_ON_MS,
    parameter int SHORT_OFF_MS  = `LED_SHORT_OFF_MS,
    parameter int GAP_MS        = `LED_GAP_MS,
    parameter int TEST_HALF_MS  = `LED_TEST_HALF_MS
)
(
    input  wire logic                   clock,        // 100 MHz system clock.
    input  wire logic                   rst_n,        // Synchronous reset, active low.
    input  wire logic                   self_test,    // Self test running, level.
    input  wire logic                   ready,        // Tests passed and address held, level.
    input  wire logic                   code_valid,   // Start or replace code, one-cycle pulse.
    input  wire logic [`LED_CODE_W-1:0] code,         // Code to flash, 0 to 99.
    input  wire logic                   code_stop,    // End code signalling, one-cycle pulse.
    output logic                        led_on,       // LED drive, high lights the LED.
    output logic                        code_active,  // High while a code is being flashed.
    output logic                        code_reject   // Out-of-range code seen, one-cycle pulse.
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************

    if (CYCLES_PER_MS < 1)
    begin : g_chk_cycles
        $error("CYCLES_PER_MS must be at least one");
    end

    if (LONG_ON_MS < 1)
    begin : g_chk_long_on
        $error("LONG_ON_MS must be at least one");
    end

    if (LONG_OFF_MS < 1)
    begin : g_chk_long_off
        $error("LONG_OFF_MS must be at least one");
    end

    if (SHORT_ON_MS < 1)
    begin : g_chk_short_on
        $error("SHORT_ON_MS must be at least one");
    end

    if (SHORT_OFF_MS < 1)
    begin : g_chk_short_off
        $error("SHORT_OFF_MS must be at least one");
    end

    if (GAP_MS < 1)
    begin : g_chk_gap
        $error("GAP_MS must be at least one");
    end

    if (TEST_HALF_MS < 1)
    begin : g_chk_test_half
        $error("TEST_HALF_MS must be at least one");
    end

    if (`LED_CODE_MAX >= (1 << `LED_CODE_W))
    begin : g_chk_code_w
        $error("Code width cannot hold the largest code");
    end

    // The phase counter must hold the longest phase of all.
    localparam int MAX_A = (GAP_MS > LONG_ON_MS) ? GAP_MS : LONG_ON_MS;
    localparam int MAX_B = (MAX_A > LONG_OFF_MS) ? MAX_A : LONG_OFF_MS;
    localparam int MAX_C = (MAX_B > SHORT_ON_MS) ? MAX_B : SHORT_ON_MS;
    localparam int MAX_D = (MAX_C > SHORT_OFF_MS) ? MAX_C : SHORT_OFF_MS;
    localparam int MAXMS = (MAX_D > TEST_HALF_MS) ? MAX_D : TEST_HALF_MS;
    localparam int MW    = $clog2(MAXMS + 1) + 1;

    // ****************************************************************
    // Time base
    // ****************************************************************

    logic tick;

    ms_tick #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_tick
    (
        .clock (clock),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // ****************************************************************
    // Code acceptance and digit split
    // ****************************************************************

    // Codes above the top value are refused and leave the pattern running.
    wire        code_ok   = (code <= `LED_CODE_W'(`LED_CODE_MAX)); // R3
    wire        code_take = code_valid && code_ok;
    wire [3:0]  tens_in   = 4'(code / `LED_CODE_W'(10));
    wire [3:0]  ones_in   = 4'(code % `LED_CODE_W'(10));

    logic [3:0] tens_reg;
    logic [3:0] ones_reg;
    logic       active_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tens_reg <= 4'h0;
            ones_reg <= 4'h0;
        end
        else if (code_take)
        begin
            tens_reg <= tens_in;
            ones_reg <= ones_in;
        end
    end

    // A new code wins over a stop arriving in the same cycle.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            active_reg <= 1'b0;
        else if (code_take)
            active_reg <= 1'b1; // R9 R10
        else if (code_stop)
            active_reg <= 1'b0;
    end

    // ****************************************************************
    // Refusal of out-of-range codes
    // ****************************************************************

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            code_reject <= 1'b0;
        else
            code_reject <= code_valid && !code_ok;
    end

    // ****************************************************************
    // Status outputs
    // ****************************************************************

    assign code_active = active_reg;

    // ****************************************************************
    // Phase sequencer
    // ****************************************************************

    status_led_pkg::led_state_t state_reg;
    status_led_pkg::led_state_t state_next;
    logic [MW-1:0]              ms_reg;
    logic [3:0]                 flash_reg;
    logic                       test_led_reg;

    // Each phase lasts this many millisecond ticks.
    logic [MW-1:0] phase_len;
    always_comb
    begin
        case (state_reg)
            status_led_pkg::ST_GAP:       phase_len = MW'(GAP_MS);       // R4
            status_led_pkg::ST_LONG_ON:   phase_len = MW'(LONG_ON_MS);   // R5
            status_led_pkg::ST_LONG_OFF:  phase_len = MW'(LONG_OFF_MS);  // R5
            status_led_pkg::ST_SHORT_ON:  phase_len = MW'(SHORT_ON_MS);  // R7
            status_led_pkg::ST_SHORT_OFF: phase_len = MW'(SHORT_OFF_MS); // R11
            default:                      phase_len = MW'(TEST_HALF_MS); // R1
        endcase
    end

    wire phase_done = tick && (ms_reg >= phase_len - MW'(1));
    wire long_last  = (flash_reg == tens_reg);  // R6
    wire short_last = (flash_reg == ones_reg);  // R8

    wire in_test      = (state_reg == status_led_pkg::ST_TEST);
    wire in_gap       = (state_reg == status_led_pkg::ST_GAP);
    wire in_long_off  = (state_reg == status_led_pkg::ST_LONG_OFF);
    wire in_short_off = (state_reg == status_led_pkg::ST_SHORT_OFF);
    wire show_ready   = ready && !self_test; // R2

    // A take restarts the pattern from the dark gap, even in mid-flash.
    // Without a code the LED follows the self-test and ready levels.
    always_comb
    begin
        state_next = state_reg;
        if (code_take)
            state_next = status_led_pkg::ST_GAP;
        else if (!active_reg)
            state_next = show_ready ? status_led_pkg::ST_READY : status_led_pkg::ST_TEST; // R2
        else if (phase_done)
        begin
            case (state_reg)
                status_led_pkg::ST_GAP:       state_next = status_led_pkg::ST_LONG_ON;
                status_led_pkg::ST_LONG_ON:   state_next = status_led_pkg::ST_LONG_OFF;
                status_led_pkg::ST_LONG_OFF:
                    state_next = long_last ? status_led_pkg::ST_SHORT_ON : status_led_pkg::ST_LONG_ON; // R6
                status_led_pkg::ST_SHORT_ON:  state_next = status_led_pkg::ST_SHORT_OFF;
                status_led_pkg::ST_SHORT_OFF:
                    state_next = short_last ? status_led_pkg::ST_GAP : status_led_pkg::ST_SHORT_ON; // R4 R8
                default:                      state_next = status_led_pkg::ST_GAP;
            endcase
        end
    end

    // ****************************************************************
    // Phase timing
    // ****************************************************************

    // Restarting the count on every phase change keeps each phase a whole number of ticks.
    wire state_change = (state_next != state_reg) || code_take;
    wire ms_clear     = state_change || phase_done;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state_reg <= status_led_pkg::ST_TEST;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ms_reg <= '0;
        else if (ms_clear)
            ms_reg <= '0;
        else if (tick)
            ms_reg <= ms_reg + MW'(1);
    end

    // ****************************************************************
    // Digit counter
    // ****************************************************************

    // Flash counter restarts when a digit's run begins.
    wire flash_reset = code_take
                    || in_gap
                    || (phase_done && in_long_off && long_last);
    wire flash_step  = phase_done
                    && (in_long_off || in_short_off);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            flash_reg <= 4'h0;
        else if (flash_reset)
            flash_reg <= 4'h0;
        else if (flash_step)
            flash_reg <= flash_reg + 4'h1;
    end

    // ****************************************************************
    // Self-test blink
    // ****************************************************************

    // The blink starts lit so the LED shows life as soon as reset lifts.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            test_led_reg <= 1'b1;
        else if (!in_test)
            test_led_reg <= 1'b1;
        else if (phase_done)
            test_led_reg <= !test_led_reg; // R1
    end

    // ****************************************************************
    // LED output
    // ****************************************************************

    // The drive is registered so the pin never shows decode glitches.
    wire next_lit  = (state_next == status_led_pkg::ST_LONG_ON) || (state_next == status_led_pkg::ST_SHORT_ON);
    wire next_test = (state_next == status_led_pkg::ST_TEST);
    wire next_rdy  = (state_next == status_led_pkg::ST_READY);
    wire led_next  = next_rdy || next_lit || (next_test && test_led_reg);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            led_on <= 1'b0;
        else
            led_on <= led_next; // R2
    end

endmodule

/* File: tb/status_led_checker.sv */
// Concurrent checks on the status LED flash encoder ports.
`timescale 1ns/1ps
`include "status_led_defs.svh"

module status_led_checker
#(
    parameter int CYCLES_PER_MS = 2,
    parameter int TEST_HALF_MS  = 3
)
(
    input wire logic                   clock,       // Clock.
    input wire logic                   rst_n,       // Reset.
    input wire logic                   self_test,   // Self test.
    input wire logic                   ready,       // Ready.
    input wire logic                   code_valid,  // Code take.
    input wire logic [`LED_CODE_W-1:0] code,        // Code.
    input wire logic                   code_stop,   // Stop.
    input wire logic                   led_on,      // LED.
    input wire logic                   code_active, // Flashing.
    input wire logic                   code_reject  // Reject.
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // Counts cycles of unchanged LED during self test.
    // ****************************************
    int   hold_cnt;
    logic led_prev;
    always_ff @(posedge clock)
    begin
        led_prev <= led_on;
        if (!rst_n || !self_test || code_active || led_on != led_prev)
            hold_cnt <= 0;
        else
            hold_cnt <= hold_cnt + 1;
    end

    property p_blink; hold_cnt <= (TEST_HALF_MS + 1) * CYCLES_PER_MS; endproperty
    a_blink: assert property (p_blink) else $error("LED stuck during self test");
    property p_ready; (!code_active && ready && !self_test) [*3] |-> led_on; endproperty
    a_ready: assert property (p_ready) else $error("LED not steady when ready");
    property p_reject; code_valid && code > 7'h63 |=> code_reject; endproperty
    a_reject: assert property (p_reject) else $error("Out of range code accepted");
    property p_no_reject; !(code_valid && code > 7'h63) |=> !code_reject; endproperty
    a_no_reject: assert property (p_no_reject) else $error("Spurious reject");
    property p_take; code_valid && code <= 7'h63 |=> code_active && !led_on; endproperty
    a_take: assert property (p_take) else $error("Code take not answered");
    property p_gap; $rose(code_active) |-> !led_on [*8]; endproperty
    a_gap: assert property (p_gap) else $error("Opening gap not dark");
    property p_keep; code_active && !code_stop |=> code_active; endproperty
    a_keep: assert property (p_keep) else $error("Pattern stopped by itself");
    property p_stop; code_stop && !code_valid |=> !code_active; endproperty
    a_stop: assert property (p_stop) else $error("Stop ignored");
    property p_on_min; code_active && $rose(led_on) |-> led_on [*4]; endproperty
    a_on_min: assert property (p_on_min) else $error("Flash too short");

    c_reject: cover property (code_reject);
    c_flash: cover property (code_active && $rose(led_on));
    c_steady: cover property (!code_active && ready && led_on);
endmodule

bind status_led_flash_encoder status_led_checker
#(.CYCLES_PER_MS(CYCLES_PER_MS), .TEST_HALF_MS(TEST_HALF_MS)) i_status_led_checker
(.clock(clock), .rst_n(rst_n), .self_test(self_test), .ready(ready), .code_valid(code_valid), .code(code),
 .code_stop(code_stop), .led_on(led_on), .code_active(code_active), .code_reject(code_reject));

/* File: tb/test_status_led_flash_encoder.sv */
// Self-checking bench for the status LED flash encoder.
`timescale 1ns/1ps
`include "status_led_defs.svh"

module test_status_led_flash_encoder;
    logic                   clock = 1'b0;
    logic                   rst_n, self_test, ready, code_valid, code_stop, led_on, code_active, code_reject;
    logic [`LED_CODE_W-1:0] code;
    logic [15:0]            lfsr = 16'hEB9B;
    logic                   prev;
    int                     err_total = 0;
    int                     cmp_count = 0;
    int                     n;
    int                     codes[6] = '{11, 30, 0, 99, 7, 23};
    int                     model_q[$];

    initial forever #5 clock = ~clock;

    // Shortened timing: one millisecond is P_MS clock cycles.
    localparam int P_MS      = 2;
    localparam int LONG_MS   = 4;
    localparam int SHORT_MS  = 2;
    localparam int GAP_MS    = 6;
    localparam int HALF_MS   = 3;
    localparam int LONG_CYC  = LONG_MS * P_MS;
    localparam int SHORT_CYC = SHORT_MS * P_MS;
    localparam int DARK_CYC  = (SHORT_MS + GAP_MS) * P_MS;

    status_led_flash_encoder #(.CYCLES_PER_MS(P_MS), .LONG_ON_MS(LONG_MS), .LONG_OFF_MS(LONG_MS),
        .SHORT_ON_MS(SHORT_MS), .SHORT_OFF_MS(SHORT_MS), .GAP_MS(GAP_MS), .TEST_HALF_MS(HALF_MS))
        i_status_led_flash_encoder
    (.clock(clock), .rst_n(rst_n), .self_test(self_test), .ready(ready), .code_valid(code_valid),
     .code(code), .code_stop(code_stop), .led_on(led_on), .code_active(code_active), .code_reject(code_reject));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        lfsr_next = {1'b0, v[15:1]} ^ (v[0] ? 16'hB400 : 16'h0000);
    endfunction

    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
            err_total++;
        end
    endtask

    task automatic run_of(input logic lvl, output int len);
        len = 0;
        while (led_on === lvl && len < 40)
        begin
            @(posedge clock);
            #1;
            len++;
        end
        if (len == 40)
        begin
            err_total++;
            finish_test();
        end
    endtask

    task automatic take(input int c);
        @(posedge clock);
        code_valid <= 1'b1;
        code       <= c[6:0];
        @(posedge clock);
        code_valid <= 1'b0;
        #1;
        if (c <= `LED_CODE_MAX)
        begin
            model_q.push_back(c);
            chk("active", 1, code_active);
            chk("led_dark", 0, led_on);
            chk("no_reject", 0, code_reject);
        end
        else
            chk("reject", 1, code_reject);
    endtask

    // Decodes one repetition from the current point through to the end of the closing gap.
    task automatic decode();
        int len, off, nl, ns, c;
        c   = model_q[$];
        nl  = 0;
        ns  = 0;
        off = 0;
        run_of(1'b0, len);
        while (off < DARK_CYC)
        begin
            run_of(1'b1, len);
            if (len > SHORT_CYC)
            begin
                nl++;
                chk("long_on", LONG_CYC, len);
            end
            else
            begin
                ns++;
                chk("short_on", SHORT_CYC, len);
            end
            run_of(1'b0, off);
            if (off < DARK_CYC)
                chk("flash_off", len > SHORT_CYC ? LONG_CYC : SHORT_CYC, off);
        end
        chk("long_count", c / 10 + 1, nl);
        chk("short_count", c % 10 + 1, ns);
        chk("gap", DARK_CYC, off);
    endtask

    initial
    begin
        rst_n      = 1'b0;
        self_test  = 1'b1;
        ready      = 1'b0;
        code_valid = 1'b0;
        code_stop  = 1'b0;
        code       = '0;
        prev       = 1'b0;
        repeat (7) @(posedge clock);
        #1;
        chk("reset_led", 0, led_on);
        chk("reset_active", 0, code_active);
        chk("reset_reject", 0, code_reject);
        @(posedge clock);
        rst_n <= 1'b1;
        n = 0;
        repeat (30)
        begin
            @(posedge clock);
            #1;
            if (led_on !== prev)
                n++;
            prev = led_on;
        end
        chk("test_blink", 1, n >= 4);
        @(posedge clock);
        self_test <= 1'b0;
        ready     <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        repeat (10)
        begin
            @(posedge clock);
            #1;
            chk("steady", 1, led_on);
        end
        foreach (codes[i])
        begin
            take(codes[i]);
            decode();
            decode();
        end
        repeat (4)
        begin
            lfsr = lfsr_next(lfsr);
            take(lfsr % 100);
            decode();
        end
        take(55);
        repeat (20) @(posedge clock);
        take(12);
        decode();
        take(100);
        take(127);
        chk("still_active", 1, code_active);
        @(posedge clock);
        code_valid <= 1'b1;
        code       <= 7'h05;
        code_stop  <= 1'b1;
        @(posedge clock);
        code_valid <= 1'b0;
        code_stop  <= 1'b0;
        model_q.push_back(5);
        #1;
        chk("take_over_stop", 1, code_active);
        decode();
        @(posedge clock);
        code_stop <= 1'b1;
        @(posedge clock);
        code_stop <= 1'b0;
        #1;
        chk("stopped", 0, code_active);
        repeat (3) @(posedge clock);
        #1;
        chk("steady_again", 1, led_on);
        finish_test();
    end

    initial
    begin
        repeat (100000) @(posedge clock);
        err_total++;
        finish_test();
    end
endmodule
